// File: inc/tidda_map.vh
// Purpose: Register map, field positions and counts of the timer event and DELTA_SIGMA_MODULATOR block
// Assumes: 8-bit register port, byte-wide registers
// Notes: Definitions only
`ifndef TIDDA_MAP_VH
`define TIDDA_MAP_VH

// ==========================================================
// Register offsets
`define TIDDA_ADDR_CNTL 8'he2
`define TIDDA_ADDR_CNTH 8'he3
`define TIDDA_ADDR_CTL 8'he4
`define TIDDA_ADDR_CCTL0 8'he5
`define TIDDA_ADDR_CCTL1 8'he6
`define TIDDA_ADDR_CCTL2 8'he7
`define TIDDA_ADDR_CC0L 8'hda
`define TIDDA_ADDR_CC0H 8'hdb
`define TIDDA_ADDR_CC1L 8'hdc
`define TIDDA_ADDR_CC1H 8'hdd
`define TIDDA_ADDR_CC2L 8'hde
`define TIDDA_ADDR_CC2H 8'hdf
`define TIDDA_ADDR_IRQ 8'hd8

// ==========================================================
// Field positions
`define TIDDA_CCTL_IM 6
`define TIDDA_CCTL_MODE 2
`define TIDDA_IRQ_OVFIM 0
`define TIDDA_IRQ_GEN 1
`define TIDDA_IRQ_FLAG 2

// ==========================================================
// Encodings and reset values
`define TIDDA_MODE_STOP 2'h0
`define TIDDA_MODE_FREE 2'h1
`define TIDDA_MODE_MOD 2'h2
`define TIDDA_MODE_UD 2'h3
`define TIDDA_CMP_DSM 3'h7
`define TIDDA_RST_BYTE 8'h00
`define TIDDA_FULL_CNT 16'hffff

// ==========================================================
// Timing counts, in timer ticks
`define TIDDA_PRE_DIV8 7'h07
`define TIDDA_PRE_DIV32 7'h1f
`define TIDDA_PRE_DIV128 7'h7f
`define TIDDA_DSM_LAST_FAST 3'h3
`define TIDDA_DSM_LAST_SLOW 3'h7

`endif

// File: rtl/tidda_timer.v
// Purpose: Timer event flags, interrupt, DMA triggers and delta-sigma audio output
// Assumes: tick_en is a one-cycle timer tick pulse from the clock controller
// Notes: Registers are byte wide on a plain strobe port, read data one cycle later
//
// How it works
// [R1] One interrupt from overflow, capture or compare
// [R2] Event flags set regardless of mask bits
// [R3] CPU flag raised only by masked-in set flag
// [R4] Request needs mask bit and global enable
// [R5] Enabling mask on set flag re-raises request
// [R6] Free/modulo: channel events and terminal count flag
// [R7] Up/down compare: ch0 and overflow at zero
// [R8] Up/down capture: overflow at zero, channels capture
// [R9] One DMA trigger pulse per channel event
// [R10] Modulator steps at tick/4 or tick/8
// [R11] Samples per period, prescaler bypassed
// [R12] Linear interpolator, or hold when filter 1x
// [R13] Shaper forces two edges per output bit
// [R14] Software uses modulo mode and ch0 compare
// [R15] Modulator starts when compare action is 111
// [R16] Counter low write clears whole counter
// [R17] Nonzero count mode runs the counter
// [R18] Software follows the modulator bring-up order
// [R19] Software writes samples low byte first
// [R20] Samples signed, two low bits forced zero
// [R21] Low byte read latches high byte
// [R22] Mode: stop, free, modulo, up/down
// [R23] Value low byte buffered until high write
// [R24] Modulator output replaces channel 1 output
`include "tidda_map.vh"
`timescale 1ns/1ps
`default_nettype none

module tidda_timer #(
	parameter ACC_W = 40
) (
	input wire clk_sys,
	input wire sys_rst,
	input wire tick_en,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	input wire [2:0] cap_pin,
	output reg [2:0] ch_out,
	output wire cpu_timer_irq_flag,
	output wire irq_req,
	output wire dma_trig_chan0,
	output wire dma_trig_chan1,
	output wire dma_trig_chan2
);

	// ==========================================================
	// Address decode
	wire wr_cntl = reg_wr && (reg_addr == `TIDDA_ADDR_CNTL);
	wire wr_ctl = reg_wr && (reg_addr == `TIDDA_ADDR_CTL);
	wire wr_irq = reg_wr && (reg_addr == `TIDDA_ADDR_IRQ);
	wire [2:0] wr_cctl;
	wire [2:0] wr_lo;
	wire [2:0] wr_hi;
	assign wr_cctl[0] = reg_wr && (reg_addr == `TIDDA_ADDR_CCTL0);
	assign wr_cctl[1] = reg_wr && (reg_addr == `TIDDA_ADDR_CCTL1);
	assign wr_cctl[2] = reg_wr && (reg_addr == `TIDDA_ADDR_CCTL2);
	assign wr_lo[0] = reg_wr && (reg_addr == `TIDDA_ADDR_CC0L);
	assign wr_lo[1] = reg_wr && (reg_addr == `TIDDA_ADDR_CC1L);
	assign wr_lo[2] = reg_wr && (reg_addr == `TIDDA_ADDR_CC2L);
	assign wr_hi[0] = reg_wr && (reg_addr == `TIDDA_ADDR_CC0H);
	assign wr_hi[1] = reg_wr && (reg_addr == `TIDDA_ADDR_CC1H);
	assign wr_hi[2] = reg_wr && (reg_addr == `TIDDA_ADDR_CC2H);

	// ==========================================================
	// Control state
	reg [1:0] mode_q;
	reg [1:0] div_q;
	reg [3:0] flag_q;
	reg [15:0] cnt_q;
	reg down_q;
	reg [6:0] pre_q;
	reg [7:0] hi_latch_q;
	reg ovf_mask_q;
	reg gen_en_q;
	reg irqf_q;
	reg [3:0] pend_q;
	wire [20:0] cctl_all;
	wire [47:0] cc_all;
	wire [2:0] ch_ev;
	wire [2:0] ch_pin;
	wire [2:0] dma_all;
	wire [15:0] cc0 = cc_all[15:0];
	wire [15:0] cc1 = cc_all[31:16];
	wire [6:0] cctl1 = cctl_all[13:7];
	wire dsm_on = (cctl1[5:3] == `TIDDA_CMP_DSM);
	wire run = (mode_q != `TIDDA_MODE_STOP); // [R17]
	wire ud_mode = (mode_q == `TIDDA_MODE_UD);

	// ==========================================================
	// Prescaler and active edge
	reg [6:0] pre_mask;
	always @*
	begin
		case (div_q)
			2'h1: pre_mask = `TIDDA_PRE_DIV8;
			2'h2: pre_mask = `TIDDA_PRE_DIV32;
			2'h3: pre_mask = `TIDDA_PRE_DIV128;
			default: pre_mask = 7'h00;
		endcase
	end
	// Prescaler not cleared on a divider write, so a change may take one period
	wire pre_hit = ((pre_q & pre_mask) == pre_mask);
	wire act = tick_en && (dsm_on || pre_hit); // [R11]
	wire step = act && run;

	// ==========================================================
	// Counter and overflow events
	wire [15:0] term = (mode_q == `TIDDA_MODE_FREE) ? `TIDDA_FULL_CNT : cc0; // [R22]
	wire wrap_ev = step && !ud_mode && (cnt_q == term); // [R6]
	wire ud_zero = step && ud_mode && down_q && (cnt_q == 16'h0001); // [R7] [R8]
	wire ovf_ev = wrap_ev || ud_zero;

	always @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cnt_q <= 16'h0000;
			down_q <= 1'b0;
			pre_q <= 7'h00;
		end
		else
		begin
			if (tick_en)
				pre_q <= pre_q + 7'h01;
			if (wr_cntl)
			begin
				cnt_q <= 16'h0000; // [R16]
				down_q <= 1'b0;
			end
			else if (step)
			begin
				if (!ud_mode)
					cnt_q <= (cnt_q == term) ? 16'h0000 : cnt_q + 16'h0001;
				else if (!down_q)
				begin
					if (cnt_q >= cc0 && cc0 != 16'h0000)
					begin
						down_q <= 1'b1;
						cnt_q <= cnt_q - 16'h0001;
					end
					else if (cc0 != 16'h0000)
						cnt_q <= cnt_q + 16'h0001;
				end
				else
				begin
					cnt_q <= cnt_q - 16'h0001;
					if (cnt_q == 16'h0001)
						down_q <= 1'b0;
				end
			end
		end
	end

	// ==========================================================
	// Channels
	genvar i;
	generate
		for (i = 0; i < 3; i = i + 1)
		begin : g_ch
			reg [6:0] cctl_q;
			reg [15:0] cc_q;
			reg [7:0] lo_q;
			reg [2:0] sync_q;
			reg out_q;
			reg dma_q;
			wire cmp_mode = cctl_q[`TIDDA_CCTL_MODE];
			wire [2:0] act_sel = cctl_q[5:3];
			wire rise = sync_q[1] && !sync_q[2];
			wire fall = !sync_q[1] && sync_q[2];
			// Modulator owns channel 1: its speed and filter bits alias mode and edges
			wire dsm_ch = (i == 1) && dsm_on; // [R24]
			wire cap_ev = run && !cmp_mode && !dsm_ch && ((cctl_q[0] && rise) || (cctl_q[1] && fall));
			wire cmp_ev = step && cmp_mode && !dsm_ch && (cnt_q == cc_q);
			// Channel 0 compare in up/down follows the zero turnaround
			wire ev = (i == 0 && ud_mode && cmp_mode) ? ud_zero : (cap_ev || cmp_ev); // [R7] [R8]
			assign ch_ev[i] = ev;
			assign cctl_all[7*i +: 7] = cctl_q;
			assign cc_all[16*i +: 16] = cc_q;
			assign ch_pin[i] = out_q;
			assign dma_all[i] = dma_q;
			always @(posedge clk_sys or posedge sys_rst)
			begin
				if (sys_rst)
				begin
					cctl_q <= 7'h00;
					cc_q <= 16'h0000;
					lo_q <= `TIDDA_RST_BYTE;
					sync_q <= 3'h0;
					out_q <= 1'b0;
					dma_q <= 1'b0;
				end
				else
				begin
					sync_q <= {sync_q[1:0], cap_pin[i]};
					dma_q <= ev; // [R9]
					if (wr_cctl[i])
						cctl_q <= reg_wdata[6:0];
					if (wr_lo[i])
						lo_q <= reg_wdata; // [R23]
					if (cap_ev)
						cc_q <= cnt_q;
					else if (wr_hi[i])
						cc_q <= {reg_wdata, lo_q}; // [R23]
					if (cmp_ev)
					begin
						case (act_sel)
							3'h0: out_q <= 1'b1;
							3'h1: out_q <= 1'b0;
							3'h2: out_q <= !out_q;
							3'h3, 3'h5: out_q <= 1'b1;
							3'h4, 3'h6: out_q <= 1'b0;
							default: out_q <= out_q;
						endcase
					end
					else if (step && cmp_mode && cnt_q == 16'h0000)
					begin
						case (act_sel)
							3'h3, 3'h5: out_q <= 1'b0;
							3'h4, 3'h6: out_q <= 1'b1;
							default: out_q <= out_q;
						endcase
					end
				end
			end
		end
	endgenerate

	assign dma_trig_chan0 = dma_all[0];
	assign dma_trig_chan1 = dma_all[1];
	assign dma_trig_chan2 = dma_all[2];

	// ==========================================================
	// Flags and interrupt
	wire [3:0] ev_all = {ch_ev, ovf_ev}; // [R1]
	wire [3:0] masks = {cctl_all[20], cctl_all[13], cctl_all[6], ovf_mask_q};
	wire [3:0] pend = flag_q & masks; // [R3]
	// Edge on masked pending, so enabling a mask over a set flag re-raises
	wire irq_new = |(pend & ~pend_q); // [R5]
	assign cpu_timer_irq_flag = irqf_q;
	assign irq_req = irqf_q && gen_en_q; // [R4]

	always @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			mode_q <= `TIDDA_MODE_STOP;
			div_q <= 2'h0;
			flag_q <= 4'h0;
			ovf_mask_q <= 1'b0;
			gen_en_q <= 1'b0;
			irqf_q <= 1'b0;
			pend_q <= 4'h0;
		end
		else
		begin
			pend_q <= pend;
			if (wr_ctl)
			begin
				mode_q <= reg_wdata[1:0]; // [R22]
				div_q <= reg_wdata[3:2];
			end
			// Writing 0 clears a flag; an event in that cycle wins
			flag_q <= (wr_ctl ? (flag_q & reg_wdata[7:4]) : flag_q) | ev_all; // [R2]
			if (wr_irq)
			begin
				ovf_mask_q <= reg_wdata[`TIDDA_IRQ_OVFIM];
				gen_en_q <= reg_wdata[`TIDDA_IRQ_GEN];
			end
			irqf_q <= (wr_irq ? (irqf_q & reg_wdata[`TIDDA_IRQ_FLAG]) : irqf_q) | irq_new; // [R3]
		end
	end

	// ==========================================================
	// Delta-sigma modulator
	reg [2:0] ph_q;
	reg [14:0] k_q;
	reg signed [15:0] x_prev_q;
	reg signed [15:0] x_cur_q;
	reg signed [ACC_W-1:0] i1_q;
	reg signed [ACC_W-1:0] i2_q;
	reg bit_q;
	wire fast = cctl1[`TIDDA_CCTL_MODE];
	wire zoh = cctl1[1]; // [R12]
	wire shaper = cctl1[0]; // [R13]
	wire [2:0] ph_last = fast ? `TIDDA_DSM_LAST_FAST : `TIDDA_DSM_LAST_SLOW;
	wire dsm_step = tick_en && (ph_q == ph_last); // [R10]
	wire [16:0] per = {1'b0, cc0} + 17'h00001;
	wire [14:0] nsp_raw = fast ? per[16:2] : {1'b0, per[16:3]};
	wire [14:0] nsp = (nsp_raw == 15'h0000) ? 15'h0001 : nsp_raw;
	wire signed [15:0] sample = {cc1[15:2], 2'b00}; // [R20]
	wire signed [ACC_W-1:0] xp_w = {{(ACC_W-16){x_prev_q[15]}}, x_prev_q};
	wire signed [ACC_W-1:0] xc_w = {{(ACC_W-16){x_cur_q[15]}}, x_cur_q};
	wire signed [ACC_W-1:0] n_w = {{(ACC_W-15){1'b0}}, nsp};
	wire signed [ACC_W-1:0] k_w = {{(ACC_W-15){1'b0}}, k_q};
	// Input carries gain N; feedback scaled by N compensates it
	wire signed [ACC_W-1:0] u_w = zoh ? xc_w * n_w : xp_w * n_w + (xc_w - xp_w) * k_w; // [R12]
	wire signed [ACC_W-1:0] fs_w = n_w <<< 15;
	wire signed [ACC_W-1:0] fb_w = bit_q ? fs_w : -fs_w;
	wire signed [ACC_W-1:0] i1_d = i1_q + u_w - fb_w;
	wire signed [ACC_W-1:0] i2_d = i2_q + i1_d - fb_w;
	wire shaped = bit_q ? (ph_q != ph_last) : (ph_q == 3'h0); // [R13]
	wire dsm_pin = shaper ? shaped : bit_q;

	always @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ph_q <= 3'h0;
			k_q <= 15'h0000;
			x_prev_q <= 16'h0000;
			x_cur_q <= 16'h0000;
			i1_q <= {ACC_W{1'b0}};
			i2_q <= {ACC_W{1'b0}};
			bit_q <= 1'b0;
		end
		else if (!dsm_on)
		begin
			// Held clear, so enabling starts from a known state at once
			ph_q <= 3'h0; // [R15]
			k_q <= 15'h0000;
			x_prev_q <= 16'h0000;
			x_cur_q <= sample;
			i1_q <= {ACC_W{1'b0}};
			i2_q <= {ACC_W{1'b0}};
			bit_q <= 1'b0;
		end
		else
		begin
			if (tick_en)
				ph_q <= (ph_q == ph_last) ? 3'h0 : ph_q + 3'h1;
			if (wrap_ev)
			begin
				x_prev_q <= x_cur_q; // [R11]
				x_cur_q <= sample;
				k_q <= 15'h0000;
			end
			else if (dsm_step && k_q != nsp)
				k_q <= k_q + 15'h0001;
			if (dsm_step)
			begin
				i1_q <= i1_d;
				i2_q <= i2_d;
				bit_q <= !i2_d[ACC_W-1];
			end
		end
	end

	// ==========================================================
	// Pins and register reads
	always @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ch_out <= 3'h0;
			reg_rdata <= `TIDDA_RST_BYTE;
			hi_latch_q <= `TIDDA_RST_BYTE;
		end
		else
		begin
			ch_out <= {ch_pin[2], dsm_on ? dsm_pin : ch_pin[1], ch_pin[0]}; // [R24]
			if (reg_rd && reg_addr == `TIDDA_ADDR_CNTL)
				hi_latch_q <= cnt_q[15:8]; // [R21]
			if (!reg_rd)
				reg_rdata <= 8'h00;
			else if (reg_addr == `TIDDA_ADDR_CNTL)
				reg_rdata <= cnt_q[7:0];
			else if (reg_addr == `TIDDA_ADDR_CNTH)
				reg_rdata <= hi_latch_q; // [R21]
			else if (reg_addr == `TIDDA_ADDR_CTL)
				reg_rdata <= {flag_q, div_q, mode_q};
			else if (reg_addr == `TIDDA_ADDR_IRQ)
				reg_rdata <= {5'h00, irqf_q, gen_en_q, ovf_mask_q};
			else if (reg_addr == `TIDDA_ADDR_CCTL0)
				reg_rdata <= {1'b0, cctl_all[6:0]};
			else if (reg_addr == `TIDDA_ADDR_CCTL1)
				reg_rdata <= {1'b0, cctl_all[13:7]};
			else if (reg_addr == `TIDDA_ADDR_CCTL2)
				reg_rdata <= {1'b0, cctl_all[20:14]};
			else if (reg_addr == `TIDDA_ADDR_CC0L)
				reg_rdata <= cc_all[7:0];
			else if (reg_addr == `TIDDA_ADDR_CC0H)
				reg_rdata <= cc_all[15:8];
			else if (reg_addr == `TIDDA_ADDR_CC1L)
				reg_rdata <= cc_all[23:16];
			else if (reg_addr == `TIDDA_ADDR_CC1H)
				reg_rdata <= cc_all[31:24];
			else if (reg_addr == `TIDDA_ADDR_CC2L)
				reg_rdata <= cc_all[39:32];
			else if (reg_addr == `TIDDA_ADDR_CC2H)
				reg_rdata <= cc_all[47:40];
			else
				reg_rdata <= 8'h00;
		end
	end

endmodule // tidda_timer

`default_nettype wire

// File: tb/tidda_timer_asserts.sv
// Purpose: Port-level checks of the timer event block
// Assumes: One clock, async active-high reset
// Notes: Bound from the bench top file
`timescale 1ns/1ps
`default_nettype none

module tidda_timer_asserts (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic tick_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [2:0] cap_pin,
	input wire logic cpu_timer_irq_flag,
	input wire logic irq_req,
	input wire logic dma_trig_chan0,
	input wire logic dma_trig_chan1,
	input wire logic dma_trig_chan2
);
	// ==========================================================
	// Helpers
	// Capture edges pass a synchroniser, so keep a short history
	logic [2:0] cap_prev_q;
	logic [7:0] cap_seen_q;
	logic irq_wr;
	logic any_dma;
	assign irq_wr = reg_wr && reg_addr == 8'hd8;
	assign any_dma = dma_trig_chan0 || dma_trig_chan1 || dma_trig_chan2;
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cap_prev_q <= 3'h0;
			cap_seen_q <= 8'h00;
		end
		else
		begin
			cap_prev_q <= cap_pin;
			cap_seen_q <= {cap_seen_q[6:0], cap_pin != cap_prev_q};
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	a_irq_gated: assert property (irq_req |-> cpu_timer_irq_flag)
		else $error("irq request without cpu flag");
	a_irq_rise: assert property ($rose(irq_req) |-> $rose(cpu_timer_irq_flag) || $past(irq_wr))
		else $error("irq request rose without cause");
	a_irq_fall: assert property ($fell(irq_req) |-> $fell(cpu_timer_irq_flag) || $past(irq_wr))
		else $error("irq request fell without cause");
	a_flag_sticky: assert property ($fell(cpu_timer_irq_flag) |-> $past(irq_wr && !reg_wdata[2]))
		else $error("cpu flag cleared without a write");
	a_flag_cause: assert property ($rose(cpu_timer_irq_flag) |-> $past(tick_en, 2) ||
		$past(reg_wr, 2) || $past(reg_wr, 3) || (|cap_seen_q))
		else $error("cpu flag rose without event or mask write");
	a_dma_tick: assert property (any_dma |-> $past(tick_en) || (|cap_seen_q))
		else $error("dma trigger without event");
	a_cnth_held: assert property (reg_rd && reg_addr == 8'he3 ##1 reg_rd && reg_addr == 8'he3
		|=> $stable(reg_rdata))
		else $error("counter high latch moved");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside read cycle");
	a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	cover property ($rose(irq_req));
	cover property (dma_trig_chan2);
	cover property ($fell(cpu_timer_irq_flag));
endmodule // tidda_timer_asserts
`default_nettype wire

// File: tb/tidda_host_model.sv
// Purpose: Tick source and DMA controller stand-in
// Assumes: Bench holds tick_on for as many cycles as ticks wanted
// Notes: Ticks are registered, never on a bench write edge
`timescale 1ns/1ps
`default_nettype none

module tidda_host_model (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic tick_on,
	input wire logic dma_trig_chan0,
	input wire logic dma_trig_chan1,
	input wire logic dma_trig_chan2,
	output logic tick_en,
	output logic [7:0] dma_cnt
);
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			tick_en <= 1'b0;
			dma_cnt <= 8'h00;
		end
		else
		begin
			tick_en <= tick_on;
			dma_cnt <= dma_cnt + 8'(dma_trig_chan0) + 8'(dma_trig_chan1) + 8'(dma_trig_chan2);
		end
	end
endmodule // tidda_host_model
`default_nettype wire

// File: tb/tidda_timer_tb.sv
// Purpose: Self-checking bench of the timer event block
// Assumes: Ticks from the host model, capture pin 0 raised once
// Notes: Register rows first, then event, latch and reset cases
`timescale 1ns/1ps
`default_nettype none

module tidda_timer_tb;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic tick_on = 1'b0;
	logic tick_en;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic [2:0] cap_pin = 3'h0;
	logic [2:0] ch_out;
	logic cpu_timer_irq_flag;
	logic irq_req;
	logic dma_trig_chan0;
	logic dma_trig_chan1;
	logic dma_trig_chan2;
	logic [7:0] dma_cnt;
	logic [16:0] rows [0:12];
	int fails = 0;
	int total_checks = 0;
	int cyc = 0;
	logic meas = 1'b0;
	logic prev_bit = 1'b0;
	int dsm_hi = 0;
	int dsm_rise = 0;

	always #20 clk_sys = ~clk_sys;

	tidda_timer tidda_timer_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .tick_en(tick_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .cap_pin(cap_pin), .ch_out(ch_out),
		.cpu_timer_irq_flag(cpu_timer_irq_flag), .irq_req(irq_req),
		.dma_trig_chan0(dma_trig_chan0), .dma_trig_chan1(dma_trig_chan1),
		.dma_trig_chan2(dma_trig_chan2));
	tidda_host_model tidda_host_model_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.tick_on(tick_on), .dma_trig_chan0(dma_trig_chan0), .dma_trig_chan1(dma_trig_chan1),
		.dma_trig_chan2(dma_trig_chan2), .tick_en(tick_en), .dma_cnt(dma_cnt));

	// ==========================================================
	// Tasks
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk("reg_rdata", reg_rdata, e);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic ticks(input int n);
		@(posedge clk_sys);
		tick_on <= 1'b1;
		repeat (n) @(posedge clk_sys);
		tick_on <= 1'b0;
		idle(4);
	endtask
	task automatic flags(input logic f, input logic q);
		chk("cpu_flag", {7'h00, cpu_timer_irq_flag}, {7'h00, f});
		chk("irq_req", {7'h00, irq_req}, {7'h00, q});
	endtask
	task automatic final_report();
		if (fails == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Hang guard, tests need about 1400 cycles
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			fails++;
			final_report();
		end
	end

	// Modulator output watch, sampled mid-cycle where it is settled
	always @(negedge clk_sys)
	begin
		if (meas && ch_out[1])
			dsm_hi++;
		if (meas && ch_out[1] && !prev_bit)
			dsm_rise++;
		prev_bit = ch_out[1];
	end

	// ==========================================================
	// Sequence
	initial
	begin
		rows = '{{1'h0, 8'he2, 8'h00}, {1'h0, 8'he3, 8'h00}, {1'h0, 8'he4, 8'h00},
			{1'h0, 8'hd8, 8'h00}, {1'h1, 8'he4, 8'h0c}, {1'h0, 8'he4, 8'h0c},
			{1'h1, 8'he7, 8'h1c}, {1'h0, 8'he7, 8'h1c}, {1'h1, 8'he3, 8'hff},
			{1'h0, 8'he3, 8'h00}, {1'h1, 8'h00, 8'hff}, {1'h0, 8'h00, 8'h00},
			{1'h1, 8'he4, 8'h00}};
		repeat (16) @(posedge clk_sys);
		sys_rst <= 1'b0;
		foreach (rows[i])
		begin
			if (rows[i][16])
				wr(rows[i][15:8], rows[i][7:0]);
			else
				rd(rows[i][15:8], rows[i][7:0]);
		end
		// Modulo 9, channel 2 compare at 5, masks off
		wr(8'he2, 8'h00);
		wr(8'hda, 8'h09);
		wr(8'hdb, 8'h00);
		wr(8'hde, 8'h05);
		wr(8'hdf, 8'h00);
		wr(8'he4, 8'h02);
		ticks(6);
		chk("dma_cnt", dma_cnt, 8'h01);
		rd(8'he4, 8'h82);
		ticks(4);
		rd(8'he4, 8'h92);
		wr(8'hd8, 8'h02);
		idle(3);
		flags(1'b0, 1'b0);
		wr(8'he7, 8'h5c);
		idle(3);
		flags(1'b1, 1'b1);
		wr(8'hd8, 8'h00);
		idle(3);
		flags(1'b0, 1'b0);
		wr(8'hd8, 8'h01);
		idle(3);
		flags(1'b1, 1'b0);
		wr(8'he4, 8'h02);
		wr(8'hd8, 8'h00);
		idle(2);
		flags(1'b0, 1'b0);
		ticks(6);
		flags(1'b1, 1'b0);
		chk("dma_cnt", dma_cnt, 8'h02);
		wr(8'hd8, 8'h06);
		idle(2);
		flags(1'b1, 1'b1);
		// Counter latch and clear
		wr(8'he4, 8'h00);
		wr(8'he2, 8'h00);
		wr(8'he4, 8'h01);
		ticks(300);
		rd(8'he2, 8'h2c);
		ticks(256);
		rd(8'he3, 8'h01);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= 8'he3;
		repeat (2) @(posedge clk_sys);
		reg_rd <= 1'b0;
		rd(8'he2, 8'h2c);
		rd(8'he3, 8'h02);
		wr(8'he2, 8'ha5);
		rd(8'he2, 8'h00);
		rd(8'he3, 8'h00);
		wr(8'he4, 8'h00);
		ticks(5);
		rd(8'he2, 8'h00);
		// Up/down to 3, channel 0 compare
		wr(8'hda, 8'h03);
		wr(8'hdb, 8'h00);
		wr(8'he5, 8'h04);
		wr(8'he4, 8'h03);
		ticks(5);
		rd(8'he4, 8'h03);
		ticks(1);
		rd(8'he4, 8'h33);
		// Up/down capture: channel 0 flag from its own edge
		wr(8'he4, 8'h03);
		wr(8'he5, 8'h01);
		@(posedge clk_sys);
		cap_pin <= 3'h1;
		idle(5);
		rd(8'he4, 8'h23);
		rd(8'hda, 8'h00);
		// Modulator bring-up in order, sample half of full scale
		wr(8'he4, 8'h00);
		cap_pin <= 3'h0;
		wr(8'he2, 8'h00);
		wr(8'hda, 8'h1f);
		wr(8'hdb, 8'h00);
		wr(8'he5, 8'h04);
		wr(8'hdc, 8'h03);
		wr(8'hdd, 8'h40);
		wr(8'he4, 8'h02);
		wr(8'he6, 8'h04);
		wr(8'he6, 8'h3c);
		tick_on <= 1'b1;
		idle(64);
		meas <= 1'b1;
		idle(256);
		meas <= 1'b0;
		// Ones density 3/4 of 64 bits, four cycles each
		chk("dsm_duty", {7'h00, dsm_hi >= 176 && dsm_hi <= 208}, 8'h01);
		wr(8'he6, 8'h3f);
		dsm_hi = 0;
		dsm_rise = 0;
		idle(8);
		meas <= 1'b1;
		idle(256);
		meas <= 1'b0;
		tick_on <= 1'b0;
		chk("dsm_edges", 8'(dsm_rise), 8'h40);
		chk("dsm_shaped", {7'h00, dsm_hi >= 148 && dsm_hi <= 172}, 8'h01);
		// Reset in mid-run
		sys_rst <= 1'b1;
		idle(2);
		sys_rst <= 1'b0;
		rd(8'he4, 8'h00);
		flags(1'b0, 1'b0);
		chk("ch_out", {5'h00, ch_out}, 8'h00);
		final_report();
	end
endmodule // tidda_timer_tb

bind tidda_timer tidda_timer_asserts tidda_timer_asserts_i (.clk_sys(clk_sys),
	.sys_rst(sys_rst), .tick_en(tick_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cap_pin(cap_pin),
	.cpu_timer_irq_flag(cpu_timer_irq_flag), .irq_req(irq_req),
	.dma_trig_chan0(dma_trig_chan0), .dma_trig_chan1(dma_trig_chan1),
	.dma_trig_chan2(dma_trig_chan2));
`default_nettype wire
